/* hdl/ulsf_line_status.sv */
// Our own choice: the strobed register port.
`timescale 1ns/100ps
module ulsf_line_status
  import ulsf_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
)
(
  input  wire logic                clk_sys,
  input  wire logic                resetn,
  input  wire logic [31:0]         reg_addr,
  input  wire logic [REG_W-1:0]    reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [REG_W-1:0]    reg_rdata,
  input  wire logic                rx_char_valid,
  input  wire logic [CHAR_W-1:0]   rx_char_data,
  input  wire logic                rx_char_parity_bad,
  output logic                     rx_data_ready_flag,
  output logic                     parity_error_flag,
  output logic                     overrun_flag,
  output logic                     fifo_mode
);
  logic [7:0]        scratch_ff;
  logic [7:0]        nxt_scratch;
  logic [7:0]        line_ctl_ff;
  logic [7:0]        nxt_line_ctl;
  logic [7:0]        fifo_ctl_ff;
  logic [7:0]        nxt_fifo_ctl;
  logic [CHAR_W-1:0] rx_hold_ff;
  logic [CHAR_W-1:0] nxt_rx_hold;
  logic              hold_full_ff;
  logic              nxt_hold_full;
  logic              pe_ff;
  logic              nxt_pe;
  logic              oe_ff;
  logic              nxt_oe;
  logic              head_seen_ff;
  logic              nxt_head_seen;
  logic [REG_W-1:0]  rdata_ff;
  logic [REG_W-1:0]  nxt_rdata;
  logic              fifo_en;
  logic              fifo_en_prev_ff;
  logic              nxt_fifo_en_prev;
  logic              fifo_flush;
  logic              wr_scratch;
  logic              wr_line_ctl;
  logic              wr_fifo_ctl;
  logic              rd_scratch;
  logic              rd_line_ctl;
  logic              rd_fifo_ctl;
  logic              rd_status;
  logic              rd_rxbuf;
  logic              char_pe;
  logic              f_push;
  logic              f_pop;
  logic [CHAR_W:0]   f_head;
  logic              f_empty;
  logic              f_full;
  logic              head_pe_event;
  logic              head_pe_new;
  logic              data_ready;
  logic [CHAR_W-1:0] rx_char_out;

  // Offset match, shared by every write and read decode
  function automatic logic hit(input logic [31:0] a, input logic [31:0] o);
    hit = (a == o);
  endfunction

  assign fifo_en    = fifo_ctl_ff[BIT_FIFO_EN];
  assign fifo_mode  = fifo_en;
  // Toggling FIFO mode empties both holding stages, so a character
  // taken in one mode is never reported under the other
  assign fifo_flush = fifo_en != fifo_en_prev_ff;

  assign wr_scratch  = reg_wr && hit(reg_addr, OFS_SCRATCH);
  assign wr_line_ctl = reg_wr && hit(reg_addr, OFS_LINE_CONTROL);
  assign wr_fifo_ctl = reg_wr && hit(reg_addr, OFS_FIFO_CONTROL);
  assign rd_scratch  = reg_rd && hit(reg_addr, OFS_SCRATCH);
  assign rd_line_ctl = reg_rd && hit(reg_addr, OFS_LINE_CONTROL);
  assign rd_fifo_ctl = reg_rd && hit(reg_addr, OFS_FIFO_CONTROL);
  assign rd_status   = reg_rd && hit(reg_addr, OFS_LINE_STATUS);
  assign rd_rxbuf    = reg_rd && hit(reg_addr, OFS_RX_BUFFER);

  assign char_pe = rx_char_parity_bad && line_ctl_ff[BIT_PARITY_EN];

  // full FIFO refuses the push, contents kept
  assign f_push = fifo_en && rx_char_valid && !f_full;
  assign f_pop  = fifo_en && rd_rxbuf && !f_empty;

  ulsf_rx_fifo #(
    .WIDTH (CHAR_W + 1),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .flush     (fifo_flush),
    .push      (f_push),
    .push_data ({char_pe, rx_char_data}),
    .pop       (f_pop),
    .head_data (f_head),
    .empty     (f_empty),
    .full      (f_full)
  );

  // tag surfaces when its character becomes the head
  assign head_pe_event = fifo_en && !f_empty && f_head[CHAR_W];
  // A head is reported once; a later status read must not see it again
  assign head_pe_new   = head_pe_event && !head_seen_ff;

  assign data_ready  = fifo_en ? !f_empty : hold_full_ff;
  assign rx_char_out = fifo_en ? f_head[CHAR_W-1:0] : rx_hold_ff;

  // scratch byte is pure storage, read by nothing else
  always_comb
  begin
    nxt_scratch  = scratch_ff;
    nxt_line_ctl = line_ctl_ff;
    nxt_fifo_ctl = fifo_ctl_ff;
    if (wr_scratch)
      nxt_scratch = reg_wdata[7:0];
    if (wr_line_ctl)
      nxt_line_ctl = reg_wdata[7:0];
    if (wr_fifo_ctl)
      nxt_fifo_ctl = reg_wdata[7:0];
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      scratch_ff  <= RST_SCRATCH;
      line_ctl_ff <= RST_CONTROL;
      fifo_ctl_ff <= RST_CONTROL;
    end
    else
    begin
      scratch_ff  <= nxt_scratch;
      line_ctl_ff <= nxt_line_ctl;
      fifo_ctl_ff <= nxt_fifo_ctl;
    end
  end

  // Previous mode, compared against the current one to detect a toggle
  always_comb
  begin
    nxt_fifo_en_prev = fifo_en;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      fifo_en_prev_ff <= 1'h0;
    else
      fifo_en_prev_ff <= nxt_fifo_en_prev;
  end

  // Single holding stage used only outside FIFO mode
  always_comb
  begin
    nxt_rx_hold   = rx_hold_ff;
    nxt_hold_full = hold_full_ff;
    // buffer read empties the holding stage
    if (!fifo_en && rd_rxbuf)
      nxt_hold_full = 1'h0;
    if (fifo_flush)
      nxt_hold_full = 1'h0;
    else if (!fifo_en && rx_char_valid)
    begin
      nxt_rx_hold   = rx_char_data;
      nxt_hold_full = 1'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_hold_ff   <= '0;
      hold_full_ff <= 1'h0;
    end
    else
    begin
      rx_hold_ff   <= nxt_rx_hold;
      hold_full_ff <= nxt_hold_full;
    end
  end

  // Sticky error flags; every set below follows the clear, so a set
  // in the cycle of a status read survives it
  always_comb
  begin
    nxt_pe        = pe_ff;
    nxt_oe        = oe_ff;
    nxt_head_seen = head_seen_ff;

    if (rd_status)
    begin
      nxt_pe = 1'h0;
      nxt_oe = 1'h0;
    end

    if (!fifo_flush && !fifo_en && rx_char_valid)
    begin
      if (hold_full_ff && !rd_rxbuf)
        nxt_oe = 1'h1;
      // Non-FIFO parity error shows as soon as received
      if (char_pe)
        nxt_pe = 1'h1;
    end

    if (!fifo_flush && fifo_en && rx_char_valid && f_full)
      nxt_oe = 1'h1;

    // an error event outranks the clear
    // parity error set from the FIFO head tag
    if (head_pe_new)
      nxt_pe = 1'h1;

    // A new head gets its own chance to report
    if (f_pop || fifo_flush)
      nxt_head_seen = 1'h0;
    else if (head_pe_event)
      nxt_head_seen = 1'h1;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      pe_ff        <= 1'h0;
      oe_ff        <= 1'h0;
      head_seen_ff <= 1'h0;
    end
    else
    begin
      pe_ff        <= nxt_pe;
      oe_ff        <= nxt_oe;
      head_seen_ff <= nxt_head_seen;
    end
  end

  // Read data stands for one cycle only, zero otherwise
  always_comb
  begin
    nxt_rdata = RD_ZERO;
    if (rd_scratch)
      nxt_rdata = {8'h00, scratch_ff};
    else if (rd_line_ctl)
      nxt_rdata = {8'h00, line_ctl_ff};
    else if (rd_fifo_ctl)
      nxt_rdata = {8'h00, fifo_ctl_ff};
    else if (rd_rxbuf)
      nxt_rdata = {8'h00, rx_char_out};
    else if (rd_status)
    begin
      // report flags as held before the clear
      nxt_rdata[BIT_DATA_READY] = data_ready;
      nxt_rdata[BIT_OVERRUN]    = oe_ff;
      nxt_rdata[BIT_PARITY_ERR] = pe_ff;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      rdata_ff <= RD_ZERO;
    else
      rdata_ff <= nxt_rdata;
  end

  assign reg_rdata          = rdata_ff;
  assign rx_data_ready_flag = data_ready;
  assign parity_error_flag  = pe_ff;
  assign overrun_flag       = oe_ff;
endmodule

/* hdl/ulsf_pkg.sv */
package ulsf_pkg;
  // Register offsets (byte addresses on the plain register port)
  localparam logic [31:0] OFS_SCRATCH      = 32'h5000111C;
  localparam logic [31:0] OFS_LINE_STATUS  = 32'h50001114;
  localparam logic [31:0] OFS_LINE_CONTROL = 32'h5000110C;
  localparam logic [31:0] OFS_FIFO_CONTROL = 32'h50001108;
  localparam logic [31:0] OFS_RX_BUFFER    = 32'h50001100;

  // Line status field positions
  localparam int BIT_DATA_READY  = 0;
  localparam int BIT_OVERRUN     = 1;
  localparam int BIT_PARITY_ERR  = 2;
  // Control field positions
  localparam int BIT_PARITY_EN   = 3;
  localparam int BIT_FIFO_EN     = 0;

  localparam int REG_W           = 16;
  localparam int CHAR_W          = 8;
  localparam int FIFO_DEPTH      = 16;

  localparam logic [7:0]  RST_SCRATCH = 8'h00;
  localparam logic [7:0]  RST_CONTROL = 8'h00;
  localparam logic [15:0] RD_ZERO     = 16'h0000;
endpackage

/* hdl/ulsf_rx_fifo.sv */
`timescale 1ns/100ps
// Receive FIFO holding each character with its parity-error tag
module ulsf_rx_fifo
  import ulsf_pkg::*;
#(
  parameter int WIDTH = CHAR_W + 1,
  parameter int DEPTH = FIFO_DEPTH
)
(
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire logic             flush,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] push_data,
  input  wire logic             pop,
  output logic      [WIDTH-1:0] head_data,
  output logic                  empty,
  output logic                  full
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ff;
  logic [AW-1:0]    rd_ff;
  logic [AW:0]      cnt_ff;
  logic [AW-1:0]    nxt_wr;
  logic [AW-1:0]    nxt_rd;
  logic [AW:0]      nxt_cnt;
  logic             do_push;
  logic             do_pop;

  assign empty     = (cnt_ff == '0);
  assign full      = (cnt_ff == (AW+1)'(DEPTH));
  assign head_data = mem[rd_ff];

  always_comb
  begin
    do_push = push && !full;
    do_pop  = pop && !empty;
    nxt_wr  = wr_ff;
    nxt_rd  = rd_ff;
    nxt_cnt = cnt_ff;
    if (flush)
    begin
      nxt_wr  = '0;
      nxt_rd  = '0;
      nxt_cnt = '0;
    end
    else
    begin
      if (do_push)
        nxt_wr = (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'h1;
      if (do_pop)
        nxt_rd = (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'h1;
      if (do_push && !do_pop)
        nxt_cnt = cnt_ff + 1'h1;
      else if (do_pop && !do_push)
        nxt_cnt = cnt_ff - 1'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  // Storage carries no reset; contents are qualified by the count
  always_ff @(posedge clk_sys)
  begin
    if (do_push && !flush)
      mem[wr_ff] <= push_data;
  end
endmodule

/* sim/tb_ulsf_line_status.sv */
`timescale 1ns/100ps
module tb_ulsf_line_status
  import ulsf_pkg::*;
;
  localparam int D = 4;
  logic             clk_sys = 1'b0;
  logic             resetn = 1'b0;
  logic [31:0]      reg_addr = 32'h0;
  logic [REG_W-1:0] reg_wdata = 16'h0;
  logic             reg_wr = 1'b0;
  logic             reg_rd = 1'b0;
  logic [REG_W-1:0] reg_rdata;
  logic             rx_v;
  logic [7:0]       rx_d;
  logic             rx_bad;
  logic             rdy;
  logic             pe;
  logic             oe;
  logic             fm;
  int               num_errors = 0;
  int               total_checks = 0;
  initial forever #4 clk_sys = ~clk_sys;
  ulsf_line_status #(.DEPTH(D)) ulsf_line_status_i (
    .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_char_valid(rx_v), .rx_char_data(rx_d),
    .rx_char_parity_bad(rx_bad), .rx_data_ready_flag(rdy),
    .parity_error_flag(pe), .overrun_flag(oe), .fifo_mode(fm));
  ulsf_rx_xmit_model ulsf_rx_xmit_model_i (
    .clk_sys(clk_sys), .rx_char_valid(rx_v), .rx_char_data(rx_d),
    .rx_char_parity_bad(rx_bad));
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rc(input string n, input logic [31:0] a,
                    input logic [15:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(n, e, reg_rdata);
    @(posedge clk_sys);
  endtask
  task automatic flags(input logic [3:0] e);
    #1;
    chk("flags", {12'h000, e}, {12'h000, fm, pe, oe, rdy});
    // Back onto the edge so the next request starts right after it
    @(posedge clk_sys);
  endtask
  task automatic send(input int n, input logic [7:0] b, input int bad);
    ulsf_rx_xmit_model_i.send(n, b, bad);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #20000;
    num_errors++;
    give_verdict;
  end
  initial
  begin
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rc("scratch", OFS_SCRATCH, 16'h0000);
    wr(OFS_SCRATCH, 16'hFFA5);
    rc("scratch", OFS_SCRATCH, 16'h00A5);
    rc("unmapped", 32'h50001104, 16'h0000);
    $display("test scratch finished");
    wr(OFS_LINE_CONTROL, 16'h0008);
    send(1, 8'h11, 0);
    flags(4'h5);
    rc("status", OFS_LINE_STATUS, 16'h0005);
    flags(4'h1);
    send(1, 8'h22, 1);
    flags(4'h3);
    rc("buffer", OFS_RX_BUFFER, 16'h0022);
    flags(4'h2);
    rc("status", OFS_LINE_STATUS, 16'h0002);
    wr(OFS_LINE_CONTROL, 16'h0000);
    send(1, 8'h33, 0);
    flags(4'h1);
    rc("buffer", OFS_RX_BUFFER, 16'h0033);
    $display("test direct finished");
    wr(OFS_LINE_CONTROL, 16'h0008);
    wr(OFS_FIFO_CONTROL, 16'h0001);
    flags(4'h8);
    rc("line ctl", OFS_LINE_CONTROL, 16'h0008);
    rc("fifo ctl", OFS_FIFO_CONTROL, 16'h0001);
    send(D + 1, 8'h40, 1);
    flags(4'hB);
    rc("status", OFS_LINE_STATUS, 16'h0003);
    rc("buffer", OFS_RX_BUFFER, 16'h0040);
    rc("status", OFS_LINE_STATUS, 16'h0005);
    for (int i = 1; i < D; i++)
      rc("buffer", OFS_RX_BUFFER, 16'h0040 + 16'(i));
    flags(4'h8);
    wr(OFS_FIFO_CONTROL, 16'h0000);
    flags(4'h0);
    $display("test fifo finished");
    give_verdict;
  end
endmodule

/* sim/ulsf_line_status_chk.sv */
`timescale 1ns/100ps
module ulsf_line_status_chk
  import ulsf_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              resetn,
  input wire logic [31:0]       reg_addr,
  input wire logic [REG_W-1:0]  reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [REG_W-1:0]  reg_rdata,
  input wire logic              rx_char_valid,
  input wire logic [CHAR_W-1:0] rx_char_data,
  input wire logic              rx_char_parity_bad,
  input wire logic              rx_data_ready_flag,
  input wire logic              parity_error_flag,
  input wire logic              overrun_flag,
  input wire logic              fifo_mode
);
  logic       par_en_ff;
  logic [7:0] scr_ff;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Shadow copies, since the checker cannot see the control registers
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      par_en_ff <= 1'b0;
      scr_ff <= 8'h00;
    end
    else if (reg_wr && reg_addr == OFS_LINE_CONTROL)
      par_en_ff <= reg_wdata[BIT_PARITY_EN];
    else if (reg_wr && reg_addr == OFS_SCRATCH)
      scr_ff <= reg_wdata[7:0];
  end
  sequence s_stat_rd;
    reg_rd && reg_addr == OFS_LINE_STATUS;
  endsequence
  a_pe_rd_clear: assert property (
    s_stat_rd ##0 (parity_error_flag && !rx_char_valid) |=> !parity_error_flag)
    else $error("parity flag survived status read");
  a_oe_rd_clear: assert property (
    s_stat_rd ##0 !rx_char_valid |=> !overrun_flag)
    else $error("overrun flag survived status read");
  a_rd_pre_clear: assert property (
    s_stat_rd |=> reg_rdata[2:0] == {$past(parity_error_flag),
      $past(overrun_flag), $past(rx_data_ready_flag)})
    else $error("status read data wrong");
  a_ovr_overwrite: assert property (
    !fifo_mode && !reg_wr && rx_char_valid && rx_data_ready_flag
    && !(reg_rd && reg_addr == OFS_RX_BUFFER) |=> overrun_flag)
    else $error("overrun not set");
  a_ready_on_char: assert property (
    rx_char_valid && !reg_wr |=> rx_data_ready_flag)
    else $error("data ready missing");
  a_ready_rd_clr: assert property (
    !fifo_mode && !rx_char_valid && reg_rd && reg_addr == OFS_RX_BUFFER
    |=> !rx_data_ready_flag)
    else $error("data ready not cleared");
  a_pe_needs_en: assert property (
    !fifo_mode && !par_en_ff && !parity_error_flag |=> !parity_error_flag)
    else $error("parity flag set while disabled");
  a_fifo_select: assert property (
    reg_wr && reg_addr == OFS_FIFO_CONTROL
    |=> fifo_mode == $past(reg_wdata[BIT_FIFO_EN]))
    else $error("fifo mode wrong");
  a_scratch_rd: assert property (
    reg_rd && reg_addr == OFS_SCRATCH |=> reg_rdata == {8'h00, scr_ff})
    else $error("scratch read wrong");
endmodule

bind ulsf_line_status ulsf_line_status_chk ulsf_line_status_chk_i (
  .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .rx_char_valid(rx_char_valid),
  .rx_char_data(rx_char_data), .rx_char_parity_bad(rx_char_parity_bad),
  .rx_data_ready_flag(rx_data_ready_flag),
  .parity_error_flag(parity_error_flag), .overrun_flag(overrun_flag),
  .fifo_mode(fifo_mode));

/* sim/ulsf_rx_xmit_model.sv */
`timescale 1ns/100ps
module ulsf_rx_xmit_model
  import ulsf_pkg::*;
(
  input  wire logic              clk_sys,
  output logic                   rx_char_valid,
  output logic      [CHAR_W-1:0] rx_char_data,
  output logic                   rx_char_parity_bad
);
  initial
  begin
    rx_char_valid = 1'b0;
    rx_char_data = 8'hA5;
    rx_char_parity_bad = 1'b1;
  end
  // Burst of n characters; bad marks the one with a parity fault
  task automatic send(input int n, input logic [7:0] base, input int bad);
    for (int i = 0; i < n; i++)
    begin
      rx_char_valid <= 1'b1;
      rx_char_data <= base + i[7:0];
      rx_char_parity_bad <= (i == bad);
      @(posedge clk_sys);
    end
    // Idle lines invert so nothing leans on a stale character
    rx_char_valid <= 1'b0;
    rx_char_data <= ~rx_char_data;
    rx_char_parity_bad <= ~rx_char_parity_bad;
  endtask
endmodule
